//--- logic/scss_pkg.sv
// shared constants and types of the switching clock select block
package scss_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int LOSS_TIME_US = 20;
  localparam int LOSS_CYC = (LOSS_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int F_MIN_KHZ = 100;
  localparam int F_MAX_KHZ = 1000;
  localparam int F_PRI_KHZ = 500;
  // half period bounds: max rate rounds up, min rate rounds down
  localparam int HALF_MIN = (1000000 + 2 * F_MAX_KHZ * CLK_PERIOD_NS - 1)
                            / (2 * F_MAX_KHZ * CLK_PERIOD_NS);
  localparam int HALF_MAX = 1000000 / (2 * F_MIN_KHZ * CLK_PERIOD_NS);
  localparam int PRI_PER = 1000000 / (F_PRI_KHZ * CLK_PERIOD_NS);
  localparam int PRI_QUARTER = PRI_PER / 4;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [31:0] OFS_OSC_HALF = 32'h0000_0000;
  localparam logic [31:0] OFS_CTRL = 32'h0000_0004;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
  localparam logic [9:0] RST_OSC_HALF = 10'h07d;
  localparam logic RST_FORCE_INT = 1'b0;
  localparam int CTRL_FORCE_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // synchronised pin inputs, index into one vector
  // ---------------------------------------------------------------
  localparam int NPIN = 9;
  localparam int P_FLOAT = 0;
  localparam int P_PH = 1;
  localparam int P_ENR = 2;
  localparam int P_ENF = 3;
  localparam int P_UVLO = 4;
  localparam int P_SSG = 5;
  localparam int P_SSB = 6;
  localparam int P_FBH = 7;
  localparam int P_CLK = 8;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {M_INT, M_EXT, M_PRI} scss_mode_e;
  typedef enum logic [1:0] {S_OFF, S_DISCH, S_RUN} scss_state_e;
  typedef struct packed {
    logic awvalid; logic [31:0] awaddr;
    logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready;
    logic arvalid; logic [31:0] araddr;
    logic rready;
  } scss_axi_req_s;
  typedef struct packed {
    logic awready; logic wready;
    logic bvalid; logic [1:0] bresp;
    logic arready;
    logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } scss_axi_rsp_s;
  typedef struct packed {
    logic rs1; logic rs2; logic tg;
  } scss_link_s;
  typedef struct packed {
    logic [NPIN-1:0] s1; logic [NPIN-1:0] s2;
    logic tg_s1; logic tg_s2; logic tg_s3;
    scss_mode_e mode; scss_state_e st;
    logic sel_ext; logic ext_ok; logic en_on;
    logic [10:0] cnt; logic [11:0] wd;
    logic [9:0] osc_half; logic force_int;
    logic aw_got; logic [31:0] aw_addr;
    logic w_got; logic [31:0] w_data; logic [3:0] w_strb;
    scss_axi_rsp_s rsp;
    logic sw_clk; logic a_out; logic a_oe; logic b_out; logic b_oe;
    logic sw_en; logic ss_dis; logic ref_ss; logic ls_allow;
    logic pu_boost; logic uvlo_hys;
  } scss_state_s;
endpackage

//--- logic/scss_top.sv
// switching clock selection, primary clock generation and enable gating
`timescale 1ns/100ps
`default_nettype none
module scss_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire scss_pkg::scss_axi_req_s axi_req,
  output scss_pkg::scss_axi_rsp_s axi_rsp,
  input wire logic freq_set_floating,
  input wire logic clock_io_a_in,
  output logic clock_io_a_out,
  output logic clock_io_a_oe,
  input wire logic phase_select_io_b_in,
  output logic phase_select_io_b_out,
  output logic phase_select_io_b_oe,
  input wire logic en_above_rise,
  input wire logic en_above_fall,
  input wire logic supply_ok,
  input wire logic softstart_at_ground,
  input wire logic softstart_below_ref,
  input wire logic feedback_above_softstart,
  output logic switch_clock,
  output logic switching_enable,
  output logic softstart_discharge,
  output logic ref_use_softstart,
  output logic low_side_allow,
  output logic en_pullup_boost,
  output logic uvlo_hyst_select
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // keep the programmed half period inside the legal rate span
  function automatic logic [9:0] clamp_half(input logic [9:0] h);
    if (h < 10'(scss_pkg::HALF_MIN)) begin
      clamp_half = 10'(scss_pkg::HALF_MIN);
    end else if (h > 10'(scss_pkg::HALF_MAX)) begin
      clamp_half = 10'(scss_pkg::HALF_MAX);
    end else begin
      clamp_half = h;
    end
  endfunction

  // register index: 0 rate, 1 control, 2 status, 3 unmapped
  function automatic logic [1:0] reg_dec(input logic [31:0] a);
    if (a == scss_pkg::OFS_OSC_HALF) begin
      reg_dec = 2'h0;
    end else if (a == scss_pkg::OFS_CTRL) begin
      reg_dec = 2'h1;
    end else if (a == scss_pkg::OFS_STATUS) begin
      reg_dec = 2'h2;
    end else begin
      reg_dec = 2'h3;
    end
  endfunction

  // ---------------------------------------------------------------
  // link domain: edge toggle on the external clock
  // ---------------------------------------------------------------
  scss_pkg::scss_link_s ln;
  scss_pkg::scss_link_s next_ln;

  // one toggle per rising edge; the reset level is brought over by two flops
  always_comb begin
    next_ln = ln;
    next_ln.rs1 = rst_n;
    next_ln.rs2 = ln.rs1;
    next_ln.tg = ln.rs2 ? ~ln.tg : 1'b0;
  end

  always_ff @(posedge clock_io_a_in) begin
    ln <= next_ln;
  end

  // ---------------------------------------------------------------
  // main domain
  // ---------------------------------------------------------------
  scss_pkg::scss_state_s st;
  scss_pkg::scss_state_s next;
  logic [scss_pkg::NPIN-1:0] pins;
  logic edge_seen;
  logic shutdown;
  logic [10:0] per;
  logic [10:0] half;
  logic int_src;
  logic ext_src;
  logic want_ext;
  logic [1:0] widx;
  logic [1:0] ridx;

  assign pins = {clock_io_a_in, feedback_above_softstart, softstart_below_ref,
                 softstart_at_ground, supply_ok, en_above_fall, en_above_rise,
                 phase_select_io_b_in, freq_set_floating};
  assign edge_seen = st.tg_s2 ^ st.tg_s3;
  assign shutdown = ~st.en_on | ~st.s2[scss_pkg::P_UVLO];
  assign half = st.mode == scss_pkg::M_PRI ? 11'(scss_pkg::PRI_PER / 2)
                : {1'b0, clamp_half(st.osc_half)};
  assign per = {half[9:0], 1'b0};
  assign int_src = st.cnt >= half;
  // a low phase strap selects the inverted input clock
  assign ext_src = st.s2[scss_pkg::P_CLK] ^ ~st.s2[scss_pkg::P_PH];
  assign want_ext = st.mode == scss_pkg::M_EXT;
  assign widx = reg_dec(st.aw_addr);
  assign ridx = reg_dec(axi_req.araddr);

  always_comb begin
    next = st;
    // all pins pass two flops; only the second one is read
    next.s1 = pins;
    next.s2 = st.s1;
    next.tg_s1 = ln.tg;
    next.tg_s2 = st.tg_s1;
    next.tg_s3 = st.tg_s2;
    // loss timer restarts on every rising edge and expires after the loss time
    if (st.s2[scss_pkg::P_FLOAT]) begin
      next.wd = 12'h000;
      next.ext_ok = 1'b0;
    end else if (edge_seen) begin
      next.wd = 12'h000;
      next.ext_ok = 1'b1;
    end else if (st.wd == 12'(scss_pkg::LOSS_CYC - 1)) begin
      next.ext_ok = 1'b0;
    end else begin
      next.wd = st.wd + 12'h001;
    end
    // mode from straps: floating rate pin wins, then a live input clock unless force_int is set
    if (st.s2[scss_pkg::P_FLOAT]) begin
      next.mode = scss_pkg::M_PRI;
    end else if (st.ext_ok && !st.force_int) begin
      next.mode = scss_pkg::M_EXT;
    end else begin
      next.mode = scss_pkg::M_INT;
    end
    // free-running period counter shared by internal and primary clocks
    next.cnt = st.cnt >= per - 11'h001 ? 11'h000 : st.cnt + 11'h001;
    // swap once the target source is low and the output is low; a lost
    // external clock may stand high forever, so leaving it waits only for the target
    if (want_ext != st.sel_ext && !(want_ext ? ext_src : int_src)
        && (!st.sw_clk || !st.ext_ok)) begin
      next.sel_ext = want_ext;
      if (!want_ext) begin
        next.cnt = 11'h000;
      end
    end
    next.sw_clk = st.st == scss_pkg::S_RUN && (st.sel_ext ? ext_src : int_src);
    // primary drives both pins; b rises a quarter period after a
    next.a_oe = st.mode == scss_pkg::M_PRI;
    next.b_oe = st.mode == scss_pkg::M_PRI;
    next.a_out = st.mode == scss_pkg::M_PRI && int_src;
    next.b_out = st.mode == scss_pkg::M_PRI
                 && (st.cnt >= 11'(scss_pkg::PRI_PER / 2 + scss_pkg::PRI_QUARTER)
                 || st.cnt < 11'(scss_pkg::PRI_QUARTER));
    // enable hysteresis: on above rising level, off below falling level
    if (st.s2[scss_pkg::P_ENR]) begin
      next.en_on = 1'b1;
    end else if (!st.s2[scss_pkg::P_ENF]) begin
      next.en_on = 1'b0;
    end
    next.pu_boost = st.en_on;
    next.uvlo_hys = ~st.s2[scss_pkg::P_UVLO];
    // start sequence: a restart always waits for a discharged soft-start
    case (st.st)
      scss_pkg::S_OFF: begin
        if (!shutdown) begin
          next.st = scss_pkg::S_DISCH;
        end
      end
      scss_pkg::S_DISCH: begin
        if (shutdown) begin
          next.st = scss_pkg::S_OFF;
        end else if (st.s2[scss_pkg::P_SSG]) begin
          next.st = scss_pkg::S_RUN;
        end
      end
      scss_pkg::S_RUN: begin
        if (shutdown) begin
          next.st = scss_pkg::S_OFF;
        end
      end
      default: begin
        next.st = scss_pkg::S_OFF;
      end
    endcase
    next.sw_en = next.st == scss_pkg::S_RUN;
    next.ss_dis = next.st != scss_pkg::S_RUN;
    next.ref_ss = st.s2[scss_pkg::P_SSB];
    // while soft-start is still below the reference and feedback is above soft-start, the low side may not sink
    next.ls_allow = next.st == scss_pkg::S_RUN
                    && !(st.s2[scss_pkg::P_SSB] && st.s2[scss_pkg::P_FBH]);
    // write address and data are taken in either order
    if (axi_req.awvalid && st.rsp.awready) begin
      next.aw_got = 1'b1;
      next.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st.rsp.wready) begin
      next.w_got = 1'b1;
      next.w_data = axi_req.wdata;
      next.w_strb = axi_req.wstrb;
    end
    if (st.rsp.bvalid && axi_req.bready) begin
      next.rsp.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.rsp.bvalid) begin
      next.aw_got = 1'b0;
      next.w_got = 1'b0;
      next.rsp.bvalid = 1'b1;
      next.rsp.bresp = widx == 2'h3 ? scss_pkg::RESP_SLVERR : scss_pkg::RESP_OKAY;
      if (widx == 2'h0) begin
        if (st.w_strb[0]) begin
          next.osc_half[7:0] = st.w_data[7:0];
        end
        if (st.w_strb[1]) begin
          next.osc_half[9:8] = st.w_data[9:8];
        end
      end
      if (widx == 2'h1 && st.w_strb[0]) begin
        next.force_int = st.w_data[scss_pkg::CTRL_FORCE_BIT];
      end
    end
    next.rsp.awready = ~next.aw_got;
    next.rsp.wready = ~next.w_got;
    // reads answer one cycle after the address is taken
    if (st.rsp.rvalid && axi_req.rready) begin
      next.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st.rsp.arready) begin
      next.rsp.rvalid = 1'b1;
      next.rsp.rresp = ridx == 2'h3 ? scss_pkg::RESP_SLVERR : scss_pkg::RESP_OKAY;
      case (ridx)
        2'h0: next.rsp.rdata = {22'h000000, st.osc_half};
        2'h1: next.rsp.rdata = {31'h00000000, st.force_int};
        2'h2: next.rsp.rdata = {24'h000000, st.en_on, st.sel_ext, st.ext_ok,
                                st.sw_en, st.st, st.mode};
        default: next.rsp.rdata = 32'h0000_0000;
      endcase
    end
    next.rsp.arready = ~next.rsp.rvalid;
    // synchronous reset
    if (!rst_n) begin
      next = '0;
      next.osc_half = scss_pkg::RST_OSC_HALF;
      next.force_int = scss_pkg::RST_FORCE_INT;
      next.ss_dis = 1'b1;
      next.rsp.awready = 1'b1;
      next.rsp.wready = 1'b1;
      next.rsp.arready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    st <= next;
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------
  assign axi_rsp = st.rsp;
  assign clock_io_a_out = st.a_out;
  assign clock_io_a_oe = st.a_oe;
  assign phase_select_io_b_out = st.b_out;
  assign phase_select_io_b_oe = st.b_oe;
  assign switch_clock = st.sw_clk;
  assign switching_enable = st.sw_en;
  assign softstart_discharge = st.ss_dis;
  assign ref_use_softstart = st.ref_ss;
  assign low_side_allow = st.ls_allow;
  assign en_pullup_boost = st.pu_boost;
  assign uvlo_hyst_select = st.uvlo_hys;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_mode_primary: assert property (
    st.s2[scss_pkg::P_FLOAT] |=> st.mode == scss_pkg::M_PRI ##1 st.a_oe && st.b_oe)
    else $error("floating rate pin did not give primary outputs");
  a_primary_period: assert property (
    (st.mode == scss_pkg::M_PRI && $past(st.mode, 2) == scss_pkg::M_PRI && $rose(st.a_out))
    |-> ##250 (st.mode != scss_pkg::M_PRI || $rose(st.a_out)))
    else $error("primary clock period is not 250 cycles");
  a_quadrature_lag: assert property (
    (st.mode == scss_pkg::M_PRI && $past(st.mode, 2) == scss_pkg::M_PRI && $rose(st.a_out))
    |-> ##62 (st.mode != scss_pkg::M_PRI || $rose(st.b_out)))
    else $error("second primary clock does not lag by a quarter period");
  a_ext_invert: assert property (
    ($past(st.sel_ext) && $past(st.st) == scss_pkg::S_RUN && !$past(st.s2[scss_pkg::P_PH]))
    |-> st.sw_clk == !$past(clock_io_a_in, 3))
    else $error("external clock not inverted with low phase strap");
  a_ext_direct: assert property (
    ($past(st.sel_ext) && $past(st.st) == scss_pkg::S_RUN && $past(st.s2[scss_pkg::P_PH]))
    |-> st.sw_clk == $past(clock_io_a_in, 3))
    else $error("external clock altered with high phase strap");
  a_loss_fallback: assert property (
    (st.wd == 12'(scss_pkg::LOSS_CYC - 1) && !edge_seen) |=> !st.ext_ok ##1
    st.mode != scss_pkg::M_EXT)
    else $error("no fallback after external clock loss");
  a_edge_restart: assert property (
    (edge_seen && !st.s2[scss_pkg::P_FLOAT]) |=> st.wd == 12'h000 && st.ext_ok)
    else $error("edge did not restart loss timer");
  a_enable_off: assert property (
    (!st.s2[scss_pkg::P_ENF] && !st.s2[scss_pkg::P_ENR]) |-> ##2 !st.sw_en)
    else $error("switching not stopped below enable threshold");
  a_uvlo_off: assert property (
    !st.s2[scss_pkg::P_UVLO] |=> !st.sw_en && st.uvlo_hys)
    else $error("switching not stopped on undervoltage");
  a_restart_discharged: assert property (
    $rose(st.sw_en) |-> $past(st.s2[scss_pkg::P_SSG]) && $past(st.st) == scss_pkg::S_DISCH)
    else $error("restart before soft-start discharge");
endmodule
`default_nettype wire

//--- verif/scss_clk_src.sv
// external clock source model standing on the far side of clock_io_a
`timescale 1ns/100ps
`default_nettype none
module scss_clk_src #(
  parameter real HALF_NS = 62.5
) (
  input wire logic run,
  input wire logic invert,
  input wire logic dut_oe,
  input wire logic dut_out,
  output logic pin
);
  logic src_clk = 1'b0;
  // toggles only while run is high, stands still low between bursts
  initial begin
    #3.3;
    forever begin
      #(HALF_NS);
      src_clk = run ? ~src_clk : 1'b0;
    end
  end
  // the block owns the wire while primary, the source then stays off it
  assign pin = dut_oe ? dut_out : (src_clk ^ (invert & run));
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench of the switching clock select block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  scss_pkg::scss_axi_req_s req = '0;
  scss_pkg::scss_axi_rsp_s rsp;
  logic floating = 1'b0, ph = 1'b0, run = 1'b0, inv = 1'b0, en_r = 1'b0, en_f = 1'b0;
  logic sup = 1'b1, ss_gnd = 1'b0, ss_low = 1'b0, fb_hi = 1'b0;
  logic a_pin, a_out, a_oe, b_out, b_oe, b_pin, sw_clk, sw_en, ss_dis, ref_ss, ls_ok, pu, hys;
  logic a_q, b_q;
  logic [31:0] v, t, ta, per, lag;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 30552;
  // phase pin: the block drives it while primary, else the strap level
  assign b_pin = b_oe ? b_out : ph;
  scss_top DUT (.clk(clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
    .freq_set_floating(floating), .clock_io_a_in(a_pin), .clock_io_a_out(a_out),
    .clock_io_a_oe(a_oe), .phase_select_io_b_in(b_pin), .phase_select_io_b_out(b_out),
    .phase_select_io_b_oe(b_oe), .en_above_rise(en_r), .en_above_fall(en_f),
    .supply_ok(sup), .softstart_at_ground(ss_gnd), .softstart_below_ref(ss_low),
    .feedback_above_softstart(fb_hi), .switch_clock(sw_clk), .switching_enable(sw_en),
    .softstart_discharge(ss_dis), .ref_use_softstart(ref_ss), .low_side_allow(ls_ok),
    .en_pullup_boost(pu), .uvlo_hyst_select(hys));
  scss_clk_src SRC (.run(run), .invert(inv), .dut_oe(a_oe), .dut_out(a_out), .pin(a_pin));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic end_sim();
    if (rq.size() != 0 || bq.size() != 0) mismatches++;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [33:0] ok(input logic [31:0] d);
    return {scss_pkg::RESP_OKAY, d};
  endfunction
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge clk);
    bq.push_back(er);
    req <= '{1'b1, a, 1'b1, d, 4'hf, 1'b1, 1'b0, 32'h0, 1'b0};
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) break;
    end
    req.bready <= 1'b0;
    if (i == 100) begin
      mismatches++;
      end_sim();
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] exp);
    int i;
    @(posedge clk);
    rq.push_back(exp);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) break;
    end
    req.rready <= 1'b0;
    if (i == 100) begin
      mismatches++;
      end_sim();
    end
  endtask
  // period of the switch clock or of the first clock, and lag of the phase pin, in clk cycles
  task automatic measure(input logic use_sw);
    ta = '1;
    per = '0;
    lag = '0;
    a_q = use_sw ? sw_clk : a_pin;
    b_q = b_pin;
    for (t = 0; t < 800; t++) begin
      @(posedge clk);
      if (b_pin && !b_q && ta != '1) lag = t - ta;
      if ((use_sw ? sw_clk : a_pin) && !a_q) begin
        if (ta != '1) per = t - ta;
        ta = t;
      end
      a_q = use_sw ? sw_clk : a_pin;
      b_q = b_pin;
    end
  endtask
  // responses are matched against the oldest note left by the bus tasks
  always @(posedge clk) begin
    if (rsp.rvalid === 1'b1 && req.rready && rq.size() > 0) begin
      chk({rsp.rresp, rsp.rdata}, rq.pop_front());
    end
    if (rsp.bvalid === 1'b1 && req.bready && bq.size() > 0) begin
      chk({32'h0, rsp.bresp}, {32'h0, bq.pop_front()});
    end
  end
  initial begin
    forever #4 clk = ~clk;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    step(2);
    rst_n <= 1'b1;
    rd(scss_pkg::OFS_OSC_HALF, ok(32'h7d));
    rd(scss_pkg::OFS_STATUS, ok(32'h0));
    rd(32'h0000_000c, {scss_pkg::RESP_SLVERR, 32'h0});
    wr(32'h0000_000c, 32'h1, scss_pkg::RESP_SLVERR);
    chk(ss_dis, 1'b1);
    wr(scss_pkg::OFS_CTRL, 32'h1, scss_pkg::RESP_OKAY);
    rd(scss_pkg::OFS_CTRL, ok(32'h1));
    wr(scss_pkg::OFS_CTRL, 32'h0, scss_pkg::RESP_OKAY);
    // both clamp edges, then random rates, must read back unchanged
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 32'd625 : (k == 1) ? 32'd63 : 32'd63 + ($unsigned($random(seed)) % 563);
      wr(scss_pkg::OFS_OSC_HALF, v, scss_pkg::RESP_OKAY);
      rd(scss_pkg::OFS_OSC_HALF, ok(v));
    end
    wr(scss_pkg::OFS_OSC_HALF, 32'd63, scss_pkg::RESP_OKAY);
    en_r <= 1'b1;
    en_f <= 1'b1;
    ss_gnd <= 1'b1;
    step(10);
    chk(sw_en, 1'b1);
    chk(pu, 1'b1);
    chk(ss_dis, 1'b0);
    rd(scss_pkg::OFS_STATUS, ok(32'h98));
    measure(1'b1);
    chk(per >= 126 && per <= 130, 1'b1);
    ss_low <= 1'b1;
    fb_hi <= 1'b1;
    step(6);
    chk(ref_ss, 1'b1);
    chk(ls_ok, 1'b0);
    ss_low <= 1'b0;
    fb_hi <= 1'b0;
    step(6);
    chk(ref_ss, 1'b0);
    chk(ls_ok, 1'b1);
    // lockout, then restart held back until soft-start is at ground
    sup <= 1'b0;
    step(6);
    chk({sw_en, hys, ss_dis}, 3'b011);
    ss_gnd <= 1'b0;
    sup <= 1'b1;
    step(10);
    chk({sw_en, hys}, 2'b00);
    ss_gnd <= 1'b1;
    step(10);
    chk(sw_en, 1'b1);
    en_r <= 1'b0;
    step(8);
    chk(sw_en, 1'b1);
    en_f <= 1'b0;
    step(8);
    chk({sw_en, pu}, 2'b00);
    en_r <= 1'b1;
    en_f <= 1'b1;
    step(10);
    // mid-run reset with the external clock running, so the link side is reset too
    inv <= 1'b1;
    run <= 1'b1;
    rst_n <= 1'b0;
    step(60);
    rst_n <= 1'b1;
    step(1);
    chk({sw_en, ss_dis, a_oe, b_oe}, 4'b0100);
    step(1);
    chk({sw_en, ss_dis, a_oe, b_oe}, 4'b0100);
    rd(scss_pkg::OFS_OSC_HALF, ok(32'h7d));
    // external clock with each strap level, then loss of it
    for (int k = 0; k < 2; k++) begin
      ph <= k[0];
      inv <= ~k[0];
      run <= 1'b1;
      step(300);
      rd(scss_pkg::OFS_STATUS, ok(32'hf9));
      a_q = a_pin;
      for (t = 0; t < 40; t++) begin
        @(posedge clk);
        if (a_pin && !a_q) break;
        a_q = a_pin;
      end
      step(4);
      chk(sw_clk, ph);
      run <= 1'b0;
      step(scss_pkg::LOSS_CYC + 300);
      rd(scss_pkg::OFS_STATUS, ok(32'h98));
    end
    floating <= 1'b1;
    step(10);
    chk({a_oe, b_oe}, 2'b11);
    rd(scss_pkg::OFS_STATUS, ok(32'h9a));
    measure(1'b0);
    chk(per, 32'd250);
    chk(lag, 32'd62);
    step(4);
    end_sim();
  end
endmodule
`default_nettype wire
